/* File: gpio_pkg.sv */
// gpio_pkg: register offsets, reset values and widths for the shared parallel io port
// assumes: word-indexed register port, 16-bit data, one port per instance
package gpio_pkg;
    localparam int DataWidth = 16;
    localparam int AddrWidth = 4;
    // register offsets
    localparam logic [3:0] DirectionOffset = 4'h0;
    localparam logic [3:0] PinLevelOffset = 4'h1;
    localparam logic [3:0] LatchOffset = 4'h2;
    localparam logic [3:0] OpenDrainOffset = 4'h3;
    localparam logic [3:0] AnalogCfgOffset = 4'h4;
    localparam logic [3:0] HoldCtrlOffset = 4'h5;
    localparam logic [3:0] ImplMaskOffset = 4'h6;
    // reset values
    localparam logic [15:0] DirectionReset = 16'hffff;
    localparam logic [15:0] LatchReset = 16'h0000;
    localparam logic [15:0] OpenDrainReset = 16'h0000;
    localparam logic [15:0] AnalogCfgReset = 16'h0000;
    localparam logic [15:0] UnmappedRead = 16'h0000;
    // hold control field
    localparam int ReleasePos = 0;
    localparam int SleepPos = 1;
    // state of the pin-hold sequencer
    typedef enum logic [2:0] {
        HOLD_FREE = 3'b001,
        HOLD_SLEEP = 3'b010,
        HOLD_WAKE = 3'b100
    } hold_state_type;
endpackage : gpio_pkg

/* File: pad_world.sv */
// pad_world: external pins of the port, seen from the board side
// assumes: pads resolved here; oe low means the port drives the pad
`timescale 1ns/10ps
`default_nettype none
module pad_world (
    // from the port
    input wire logic [15:0] padOut,
    input wire logic [15:0] padOe,
    // board level on undriven pins
    input wire logic [15:0] extLevel,
    // back to the port
    output logic [15:0] padIn
);
    // =====================================================
    // pad resolution
    // a driven pad shows its own level, others take the board level
    assign padIn = (padOut & ~padOe) | (extLevel & padOe);
endmodule // pad_world
`default_nettype wire

/* File: pin_ctrl_if.sv */
// pin_ctrl_if: per-pin control bundle between the port top and its pin mux
// assumes: one clock domain, width set by the instantiating module
`timescale 1ns/10ps
`default_nettype none
interface pin_ctrl_if #(parameter int Width = 16);
    logic [Width-1:0] latchBits;
    logic [Width-1:0] dirBits;
    logic [Width-1:0] odBits;
    logic [Width-1:0] implBits;
    logic [Width-1:0] padOut;
    logic [Width-1:0] padOe;
    logic [Width-1:0] portDrive;
    modport ctrl (output latchBits, output dirBits, output odBits, output implBits,
        input padOut, input padOe, input portDrive);
    modport mux (input latchBits, input dirBits, input odBits, input implBits,
        output padOut, output padOe, output portDrive);
endinterface : pin_ctrl_if
`default_nettype wire

/* File: pin_mux.sv */
// pin_mux: per-pin ownership mux between port bit and peripheral
// assumes: peripheral signals are on the core clock; oe low means driving
`timescale 1ns/10ps
`default_nettype none
module pin_mux #(
    parameter int Width = 16
) (
    // controls from the port
    pin_ctrl_if.mux ctl,
    // peripheral side
    input wire logic [Width-1:0] periphEn,
    input wire logic [Width-1:0] periphDriving,
    input wire logic [Width-1:0] periphOut
);
    genvar b;
    generate
        for (b = 0; b < Width; b++) begin : g_pin
            logic owned;
            logic portOut;
            assign owned = periphEn[b] & periphDriving[b];
            // port drives when output dir and bit exists
            assign portOut = ~ctl.dirBits[b] & ctl.implBits[b];
            // open drain: release instead of driving high
            always_comb begin
                if (owned) begin
                    ctl.padOut[b] = periphOut[b];
                    ctl.padOe[b] = 1'b0;
                end else if (portOut) begin
                    ctl.padOut[b] = ctl.odBits[b] ? 1'b0 : ctl.latchBits[b];
                    ctl.padOe[b] = ctl.odBits[b] & ctl.latchBits[b];
                end else begin
                    ctl.padOut[b] = 1'b0;
                    ctl.padOe[b] = 1'b1;
                end
            end
            assign ctl.portDrive[b] = ~owned & portOut & ~(ctl.odBits[b] & ctl.latchBits[b]);
        end
    endgenerate
endmodule // pin_mux
`default_nettype wire

/* File: pin_sync.sv */
// pin_sync: three-stage synchroniser with agreement filter for pad inputs
// assumes: asynchronous pad levels, single core clock
`timescale 1ns/10ps
`default_nettype none
module pin_sync #(
    parameter int Width = 16
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // levels
    input wire logic [Width-1:0] asyncIn,
    output logic [Width-1:0] syncOut
);
    logic [Width-1:0] st1_q;
    logic [Width-1:0] st2_q;
    logic [Width-1:0] st3_q;
    logic [Width-1:0] out_q;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            st1_q <= '0;
            st2_q <= '0;
            st3_q <= '0;
        end else begin
            st1_q <= asyncIn;
            st2_q <= st1_q;
            st3_q <= st2_q;
        end
    end

    // a change counts only once stages two and three agree
    genvar b;
    generate
        for (b = 0; b < Width; b++) begin : g_agree
            always_ff @(posedge core_clk or posedge rst) begin
                if (rst) begin
                    out_q[b] <= 1'b0;
                end else if (st2_q[b] == st3_q[b]) begin
                    out_q[b] <= st3_q[b];
                end
            end
        end
    endgenerate

    assign syncOut = out_q;
endmodule // pin_sync
`default_nettype wire

/* File: shared_parallel_io_port.sv */
// shared_parallel_io_port: one parallel port of up to sixteen shared pins
// assumes: word register port with one-cycle read data, pads outside resolve oe
//
// Behaviour
// - active enabled peripheral owns pin data and enable; port driver off; pin readable
// - enabled but idle peripheral leaves pin to port latch and direction
// - sharing peripheral's input masked on pins the port mux currently drives; released open-drain pins pass their level
// - direction bit one means input, zero enables the output driver
// - every reset sets all direction bits, making pins inputs
// - latch register reads latch contents; writes update only latch
// - pin level register reads pins; writes land in the latch
// - unimplemented bits read zero in latch, direction and pin level
// - open-drain bit set drives low only, never high, on pins no active peripheral owns
// - analog-configured pins read zero in pin level register
// - pin level reads show a port write or direction change from six cycles after the write
// - pin states frozen in deep sleep and held after wake until release cleared
// - clearing release returns pins to direction and latch control
`timescale 1ns/10ps
`default_nettype none
module shared_parallel_io_port #(
    parameter int Width = gpio_pkg::DataWidth,
    parameter logic [15:0] ImplMask = 16'hffff
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // register port
    input wire logic [3:0] regAddr,
    input wire logic [15:0] regWdata,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [15:0] regRdata,
    // power management
    input wire logic deepSleep,
    // peripherals
    input wire logic [Width-1:0] periphEn,
    input wire logic [Width-1:0] periphDriving,
    input wire logic [Width-1:0] periphOut,
    output logic [Width-1:0] periphIn,
    // pads
    input wire logic [Width-1:0] padIn,
    output logic [Width-1:0] padOut,
    output logic [Width-1:0] padOe
);
    // ==========================================================
    // registers
    logic [Width-1:0] dir_q;
    logic [Width-1:0] lat_q;
    logic [Width-1:0] od_q;
    logic [Width-1:0] ana_q;
    logic release_q;
    logic [Width-1:0] impl;
    logic [Width-1:0] pinSync;
    logic [Width-1:0] pinLevel;
    logic [Width-1:0] muxOut;
    logic [Width-1:0] muxOe;
    logic [Width-1:0] padOut_q;
    logic [Width-1:0] padOe_q;
    logic [Width-1:0] periphIn_q;
    logic [15:0] rdata_q;
    logic [15:0] rdata_d;
    logic sleep_q;
    gpio_pkg::hold_state_type hold_q;
    logic frozen;
    logic wrDir;
    logic wrLat;

    assign impl = ImplMask[Width-1:0];
    assign wrDir = regWrite && regAddr == gpio_pkg::DirectionOffset;
    assign wrLat = regWrite && (regAddr == gpio_pkg::LatchOffset || regAddr == gpio_pkg::PinLevelOffset);

    pin_ctrl_if #(.Width(Width)) ctl ();
    assign ctl.latchBits = lat_q;
    assign ctl.dirBits = dir_q;
    assign ctl.odBits = od_q;
    assign ctl.implBits = impl;
    assign muxOut = ctl.padOut;
    assign muxOe = ctl.padOe;

    pin_mux #(.Width(Width)) u_mux (
        .ctl(ctl.mux),
        .periphEn(periphEn),
        .periphDriving(periphDriving),
        .periphOut(periphOut)
    );

    pin_sync #(.Width(Width)) u_sync (
        .core_clk(core_clk),
        .rst(rst),
        .asyncIn(padIn),
        .syncOut(pinSync)
    );

    // ==========================================================
    // control registers
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            dir_q <= gpio_pkg::DirectionReset[Width-1:0];
        end else if (wrDir) begin
            dir_q <= regWdata[Width-1:0] | ~impl;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            lat_q <= gpio_pkg::LatchReset[Width-1:0];
        end else if (wrLat) begin
            lat_q <= regWdata[Width-1:0] & impl;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            od_q <= gpio_pkg::OpenDrainReset[Width-1:0];
        end else if (regWrite && regAddr == gpio_pkg::OpenDrainOffset) begin
            od_q <= regWdata[Width-1:0] & impl;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            ana_q <= gpio_pkg::AnalogCfgReset[Width-1:0];
        end else if (regWrite && regAddr == gpio_pkg::AnalogCfgOffset) begin
            ana_q <= regWdata[Width-1:0] & impl;
        end
    end

    // ==========================================================
    // deep sleep hold sequencer
    // release sets on sleep entry; software may only clear it, and
    // entry wins over a clear in the same cycle
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            sleep_q <= 1'b0;
        end else begin
            sleep_q <= deepSleep;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            release_q <= 1'b0;
        end else if (deepSleep) begin
            release_q <= 1'b1;
        end else if (regWrite && regAddr == gpio_pkg::HoldCtrlOffset && !regWdata[gpio_pkg::ReleasePos]) begin
            release_q <= 1'b0;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            hold_q <= gpio_pkg::HOLD_FREE;
        end else begin
            case (hold_q)
                gpio_pkg::HOLD_FREE: begin
                    if (deepSleep) begin
                        hold_q <= gpio_pkg::HOLD_SLEEP;
                    end
                end
                gpio_pkg::HOLD_SLEEP: begin
                    if (!deepSleep) begin
                        hold_q <= gpio_pkg::HOLD_WAKE;
                    end
                end
                gpio_pkg::HOLD_WAKE: begin
                    if (deepSleep) begin
                        hold_q <= gpio_pkg::HOLD_SLEEP;
                    end else if (!release_q) begin
                        hold_q <= gpio_pkg::HOLD_FREE;
                    end
                end
                default: begin
                    hold_q <= gpio_pkg::HOLD_FREE;
                end
            endcase
        end
    end

    assign frozen = deepSleep || hold_q != gpio_pkg::HOLD_FREE;

    // ==========================================================
    // pad outputs, frozen while held
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            padOut_q <= '0;
            padOe_q <= '1;
        end else if (!frozen) begin
            padOut_q <= muxOut;
            padOe_q <= muxOe;
        end
    end

    // peripheral input: the port's own driven value is masked off
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            periphIn_q <= '0;
        end else begin
            periphIn_q <= pinSync & ~ctl.portDrive;
        end
    end

    // ==========================================================
    // register reads
    // pin level passes the synchroniser, so a read right after a write
    // sees the old pin; software waits as the timing note says
    assign pinLevel = pinSync & ~ana_q & impl;

    always_comb begin
        rdata_d = gpio_pkg::UnmappedRead;
        case (regAddr)
            gpio_pkg::DirectionOffset: rdata_d[Width-1:0] = dir_q & impl;
            gpio_pkg::PinLevelOffset: rdata_d[Width-1:0] = pinLevel;
            gpio_pkg::LatchOffset: rdata_d[Width-1:0] = lat_q;
            gpio_pkg::OpenDrainOffset: rdata_d[Width-1:0] = od_q;
            gpio_pkg::AnalogCfgOffset: rdata_d[Width-1:0] = ana_q;
            gpio_pkg::HoldCtrlOffset: begin
                rdata_d[gpio_pkg::ReleasePos] = release_q;
                rdata_d[gpio_pkg::SleepPos] = sleep_q;
            end
            gpio_pkg::ImplMaskOffset: rdata_d[Width-1:0] = impl;
            default: rdata_d = gpio_pkg::UnmappedRead;
        endcase
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            rdata_q <= '0;
        end else if (regRead) begin
            rdata_q <= rdata_d;
        end else begin
            rdata_q <= '0;
        end
    end

    assign regRdata = rdata_q;
    assign padOut = padOut_q;
    assign padOe = padOe_q;
    assign periphIn = periphIn_q;

    // ==========================================================
    // checks
    property p_reset_inputs;
        @(posedge core_clk) $fell(rst) |-> dir_q == (gpio_pkg::DirectionReset[Width-1:0]);
    endproperty
    a_reset_inputs: assert property (p_reset_inputs) else $error("direction not all input after reset");

    property p_pin_write_latch;
        @(posedge core_clk) disable iff (rst)
            regWrite && regAddr == gpio_pkg::PinLevelOffset |=> lat_q == ($past(regWdata[Width-1:0]) & impl);
    endproperty
    a_pin_write_latch: assert property (p_pin_write_latch) else $error("pin level write missed latch");

    property p_latch_read;
        @(posedge core_clk) disable iff (rst)
            regRead && regAddr == gpio_pkg::LatchOffset && !wrLat |=> regRdata[Width-1:0] == lat_q;
    endproperty
    a_latch_read: assert property (p_latch_read) else $error("latch read wrong");

    property p_analog_zero;
        @(posedge core_clk) disable iff (rst)
            regRead && regAddr == gpio_pkg::PinLevelOffset |=> (regRdata[Width-1:0] & $past(ana_q)) == '0;
    endproperty
    a_analog_zero: assert property (p_analog_zero) else $error("analog pin read nonzero");

    property p_unimpl_zero;
        @(posedge core_clk) disable iff (rst)
            regRead |=> (regRdata[Width-1:0] & ~impl) == '0 || $past(regAddr) == gpio_pkg::ImplMaskOffset;
    endproperty
    a_unimpl_zero: assert property (p_unimpl_zero) else $error("unimplemented bit read nonzero");

    property p_od_no_high;
        @(posedge core_clk) disable iff (rst)
            1'b1 |-> ((padOut & ~padOe & $past(od_q) & ~$past(periphEn & periphDriving)) == '0) || frozen || $past(frozen);
    endproperty
    a_od_no_high: assert property (p_od_no_high) else $error("open drain pin driven high");

    property p_frozen_hold;
        @(posedge core_clk) disable iff (rst)
            frozen && $past(frozen) |-> $stable(padOut) && $stable(padOe);
    endproperty
    a_frozen_hold: assert property (p_frozen_hold) else $error("pins moved while held");

    property p_release_unfreeze;
        @(posedge core_clk) disable iff (rst)
            hold_q == gpio_pkg::HOLD_WAKE && !release_q && !deepSleep |=> ##1 padOe == $past(muxOe);
    endproperty
    a_release_unfreeze: assert property (p_release_unfreeze) else $error("pins not released");

    property p_input_no_drive;
        @(posedge core_clk) disable iff (rst)
            !frozen && $past(!frozen) && $past(dir_q == '1) && $past(periphEn == '0) |-> padOe == '1;
    endproperty
    a_input_no_drive: assert property (p_input_no_drive) else $error("input pin driven");

    // pads lag the mux by one edge, so owners are taken from the cycle before
    property p_owned_pin;
        @(posedge core_clk) disable iff (rst)
            !$past(frozen) |->
                (((padOut ^ $past(periphOut)) | padOe) & $past(periphEn & periphDriving)) == '0;
    endproperty
    a_owned_pin: assert property (p_owned_pin) else $error("owned pin not given to peripheral");

    property p_idle_periph_port;
        @(posedge core_clk) disable iff (rst)
            !$past(frozen) |->
                (((padOut ^ $past(lat_q)) | padOe)
                    & $past(periphEn & ~periphDriving & ~dir_q & ~od_q & impl)) == '0;
    endproperty
    a_idle_periph_port: assert property (p_idle_periph_port) else $error("idle peripheral kept the pin");

    property p_no_loop_through;
        @(posedge core_clk) disable iff (rst)
            (periphIn & $past(ctl.portDrive)) == '0;
    endproperty
    a_no_loop_through: assert property (p_no_loop_through) else $error("port drive seen by peripheral");

    property p_dir_write;
        @(posedge core_clk) disable iff (rst)
            regWrite && regAddr == gpio_pkg::DirectionOffset |=> dir_q == ($past(regWdata[Width-1:0]) | ~impl);
    endproperty
    a_dir_write: assert property (p_dir_write) else $error("direction write lost");

    property p_latch_write_only;
        @(posedge core_clk) disable iff (rst)
            regWrite && regAddr == gpio_pkg::LatchOffset |=>
                lat_q == ($past(regWdata[Width-1:0]) & impl) && $stable(dir_q) && $stable(od_q);
    endproperty
    a_latch_write_only: assert property (p_latch_write_only) else $error("latch write touched other state");

    property p_pin_read;
        @(posedge core_clk) disable iff (rst)
            regRead && regAddr == gpio_pkg::PinLevelOffset |=> regRdata[Width-1:0] == $past(pinLevel);
    endproperty
    a_pin_read: assert property (p_pin_read) else $error("pin level read wrong");

    property p_release_set;
        @(posedge core_clk) disable iff (rst)
            deepSleep |=> release_q;
    endproperty
    a_release_set: assert property (p_release_set) else $error("release not set in deep sleep");

    // a clear in the entry cycle loses, so entry is excluded here
    property p_release_clear;
        @(posedge core_clk) disable iff (rst)
            regWrite && regAddr == gpio_pkg::HoldCtrlOffset && !regWdata[gpio_pkg::ReleasePos] && !deepSleep
                |=> !release_q;
    endproperty
    a_release_clear: assert property (p_release_clear) else $error("release not cleared");
endmodule // shared_parallel_io_port
`default_nettype wire

/* File: testbench.sv */
// testbench: self-checking bench for shared_parallel_io_port
// assumes: pad_world on the pads, bench plays software and peripherals
`timescale 1ns/10ps
`default_nettype none
module testbench;
    localparam logic [15:0] Mask = 16'h7fff;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic [3:0] regAddr = 4'h0;
    logic [15:0] regWdata = 16'h0000;
    logic regWrite = 1'b0;
    logic regRead = 1'b0;
    logic [15:0] regRdata;
    logic deepSleep = 1'b0;
    logic [15:0] periphEn = 16'h0000;
    logic [15:0] periphDriving = 16'h0000;
    logic [15:0] periphOut = 16'h0000;
    logic [15:0] periphIn;
    logic [15:0] padIn;
    logic [15:0] padOut;
    logic [15:0] padOe;
    logic [15:0] extLevel = 16'h0000;
    logic readPend = 1'b0;
    logic [15:0] expQ[$];
    logic [15:0] v;
    logic [15:0] w;
    int error_cnt = 0;
    int checked = 0;
    integer seed = 55389;

    shared_parallel_io_port #(.Width(16), .ImplMask(Mask)) i_dut (
        .core_clk(core_clk), .rst(rst), .regAddr(regAddr), .regWdata(regWdata),
        .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata), .deepSleep(deepSleep),
        .periphEn(periphEn), .periphDriving(periphDriving), .periphOut(periphOut),
        .periphIn(periphIn), .padIn(padIn), .padOut(padOut), .padOe(padOe));
    pad_world i_pads (.padOut(padOut), .padOe(padOe), .extLevel(extLevel), .padIn(padIn));

    initial begin
        forever #50 core_clk = ~core_clk;
    end

    // =====================================================
    // checking
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // read data stand only in the cycle after the strobe
    always @(posedge core_clk) begin
        if (readPend) begin
            if (expQ.size() == 0) begin
                check(regRdata, 16'hxxxx);
            end else begin
                check(regRdata, expQ.pop_front());
            end
        end
        readPend <= regRead;
    end

    task automatic give_verdict();
        $display("comparisons %0d, mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // =====================================================
    // register bus
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge core_clk);
        regAddr <= a;
        regWdata <= d;
        regWrite <= 1'b1;
        @(posedge core_clk);
        regWrite <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, input logic [15:0] exp);
        @(posedge core_clk);
        regAddr <= a;
        regRead <= 1'b1;
        expQ.push_back(exp);
        @(posedge core_clk);
        regRead <= 1'b0;
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge core_clk);
    endtask

    // =====================================================
    // watchdog: the whole sequence needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge core_clk);
        error_cnt++;
        give_verdict();
    end

    // =====================================================
    // main sequence
    initial begin
        idle(6);
        rst <= 1'b0;
        check(padOe & Mask, Mask);
        rd(gpio_pkg::DirectionOffset, gpio_pkg::DirectionReset & Mask);
        rd(gpio_pkg::LatchOffset, gpio_pkg::LatchReset);
        rd(gpio_pkg::OpenDrainOffset, gpio_pkg::OpenDrainReset);
        rd(gpio_pkg::AnalogCfgOffset, gpio_pkg::AnalogCfgReset);
        rd(4'h7, gpio_pkg::UnmappedRead);
        rd(gpio_pkg::ImplMaskOffset, Mask);
        // latch versus pins, with the pins following the latch
        v = 16'($random(seed));
        extLevel <= 16'($random(seed));
        wr(gpio_pkg::LatchOffset, v);
        rd(gpio_pkg::LatchOffset, v & Mask);
        wr(gpio_pkg::DirectionOffset, 16'h0000);
        rd(gpio_pkg::DirectionOffset, 16'h0000);
        idle(2);
        check(padOe & Mask, 16'h0000);
        check(padOut & Mask, v & Mask);
        idle(6);
        rd(gpio_pkg::PinLevelOffset, v & Mask);
        w = 16'($random(seed));
        wr(gpio_pkg::PinLevelOffset, w);
        rd(gpio_pkg::LatchOffset, w & Mask);
        // analog pins read zero; software makes them inputs first
        wr(gpio_pkg::DirectionOffset, 16'h00ff);
        wr(gpio_pkg::AnalogCfgOffset, 16'h00ff);
        idle(8);
        rd(gpio_pkg::PinLevelOffset, w & Mask & 16'hff00);
        wr(gpio_pkg::AnalogCfgOffset, 16'h0000);
        wr(gpio_pkg::DirectionOffset, 16'h0000);
        // open drain: driven only where the latch is low
        wr(gpio_pkg::LatchOffset, 16'h00f0);
        wr(gpio_pkg::OpenDrainOffset, 16'hffff);
        idle(3);
        check(padOe & Mask, 16'h00f0 & Mask);
        check(padOut & ~padOe & Mask, 16'h0000);
        wr(gpio_pkg::OpenDrainOffset, 16'h0000);
        // peripheral owns bit 0, bit 1 enabled but idle, bit 2 input
        wr(gpio_pkg::LatchOffset, 16'h0002);
        wr(gpio_pkg::DirectionOffset, 16'hfffc);
        periphEn <= 16'h0003;
        periphDriving <= 16'h0001;
        periphOut <= 16'h0001;
        idle(8);
        check(padOe & 16'h0001, 16'h0000);
        check(padOut & 16'h0001, 16'h0001);
        check({14'h0000, padOe[1], padOut[1]}, 16'h0001);
        check(periphIn & Mask, (16'h0001 | (extLevel & 16'hfffc)) & Mask);
        rd(gpio_pkg::PinLevelOffset, (16'h0003 | (extLevel & 16'hfffc)) & Mask);
        periphEn <= 16'h0000;
        periphDriving <= 16'h0000;
        // deep sleep hold and release
        v = 16'($random(seed));
        wr(gpio_pkg::LatchOffset, v);
        wr(gpio_pkg::DirectionOffset, 16'h0000);
        idle(3);
        deepSleep <= 1'b1;
        idle(2);
        wr(gpio_pkg::LatchOffset, ~v);
        wr(gpio_pkg::DirectionOffset, 16'hffff);
        idle(3);
        check(padOut & Mask, v & Mask);
        rd(gpio_pkg::HoldCtrlOffset, 16'h0003);
        deepSleep <= 1'b0;
        idle(3);
        check(padOut & Mask, v & Mask);
        check(padOe & Mask, 16'h0000);
        rd(gpio_pkg::HoldCtrlOffset, 16'h0001);
        wr(gpio_pkg::DirectionOffset, 16'h0000);
        wr(gpio_pkg::HoldCtrlOffset, 16'h0000);
        idle(3);
        check(padOut & Mask, ~v & Mask);
        rd(gpio_pkg::HoldCtrlOffset, 16'h0000);
        idle(3);
        give_verdict();
    end
endmodule // testbench
`default_nettype wire
